// File: rtl/sacr_pkg.sv
package sacr_pkg;
    // Register offsets
    localparam logic [7:0] SACR_SENSOR_CTRL_OFS  = 8'h17;
    localparam logic [7:0] SACR_VOLT0_LIM_OFS    = 8'h19;
    localparam logic [7:0] SACR_VOLT1_LIM_OFS    = 8'h1A;
    localparam logic [7:0] SACR_TEMP_LIM_OFS     = 8'h1B;
    localparam logic [7:0] SACR_LINK_EN_OFS      = 8'h1C;
    localparam logic [7:0] SACR_MON_EN_OFS       = 8'h1D;
    localparam logic [7:0] SACR_BC_EN_OFS        = 8'h1E;
    localparam logic [7:0] SACR_POL_OFS          = 8'h20;
    localparam logic [7:0] SACR_MON_ST_OFS       = 8'h40;
    localparam logic [7:0] SACR_LINK_ST_OFS      = 8'h41;
    localparam logic [7:0] SACR_BC_ST_OFS        = 8'h42;
    localparam logic [7:0] SACR_PEAK_OFS         = 8'h43;
    localparam logic [7:0] SACR_FLOOR_OFS        = 8'h44;
    // Reset values
    localparam logic [7:0] SACR_SENSOR_CTRL_RST  = 8'h3C;
    localparam logic [7:0] SACR_LIM_RST          = 8'h62;
    localparam logic [7:0] SACR_LINK_EN_RST      = 8'h3F;
    localparam logic [7:0] SACR_MON_EN_RST       = 8'h00;
    localparam logic [7:0] SACR_BC_EN_RST        = 8'h00;
    localparam logic [7:0] SACR_POL_RST          = 8'h00;
    localparam logic [2:0] SACR_PEAK_RST         = 3'h0;
    localparam logic [2:0] SACR_FLOOR_RST        = 3'h7;
    // Field positions
    localparam int SACR_UPPER_LSB   = 4;
    localparam int SACR_LOWER_LSB   = 0;
    localparam int SACR_MON_RUN_LSB = 2;
    localparam int SACR_PIN_SEL_LSB = 0;
    localparam logic [1:0] SACR_MON_RUN = 2'h3;
    localparam int SACR_MON_BITS  = 6;
    localparam int SACR_LINK_BITS = 6;
    localparam int SACR_BC_BITS   = 7;
    localparam int SACR_LANES     = 5;
    localparam logic [7:0] SACR_POL_MASK = 8'h1F;
    // Monitor status bit positions
    localparam int SACR_T_OVER  = 5;
    localparam int SACR_T_UNDER = 4;
    localparam int SACR_VOLT1_OVER_ALARM_ON = 3;
    localparam int SACR_V1_UNDR = 2;
    localparam int SACR_VOLT0_OVER_ALARM_ON = 1;
    localparam int SACR_V0_UNDR = 0;
    // Link status bit positions
    localparam int SACR_NO_FRAME  = 5;
    localparam int SACR_PHY_SYNC  = 4;
    localparam int SACR_PHY_CTRL  = 3;
    localparam int SACR_HDR_ECC   = 2;
    localparam int SACR_CHKSUM    = 1;
    localparam int SACR_PKT_LEN   = 0;
    // Back-channel status bit positions
    localparam int SACR_TGT_TMO   = 6;
    localparam int SACR_TGT_FAULT = 5;
    localparam int SACR_CTL_TMO   = 4;
    localparam int SACR_CTL_FAULT = 3;
    localparam int SACR_BC_DATA   = 2;
    localparam int SACR_BC_CRC    = 1;
    localparam int SACR_BC_LINK   = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sacr_bus_req_t;

    typedef struct packed {
        logic       vld;
        logic [2:0] volt0;
        logic [2:0] volt1;
        logic [2:0] temp;
    } sacr_meas_t;

    typedef struct packed {
        logic [SACR_LANES-1:0] p;
        logic [SACR_LANES-1:0] n;
    } sacr_lanes_t;
endpackage : sacr_pkg

// File: rtl/sacr_regs.sv
`timescale 1ns/1ps
module sacr_regs (
    // Clock and reset
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_rst_b,
    // Register port
    input  wire sacr_pkg::sacr_bus_req_t           i_bus,
    output logic [7:0]                             o_rdata,
    // Monitor readings
    input  wire sacr_pkg::sacr_meas_t              i_meas,
    // Error event pulses
    input  wire logic [sacr_pkg::SACR_LINK_BITS-1:0] i_link_err,
    input  wire logic [sacr_pkg::SACR_BC_BITS-1:0]   i_bc_err,
    // Lanes from sensor and to receiver
    input  wire sacr_pkg::sacr_lanes_t             i_lanes,
    output sacr_pkg::sacr_lanes_t                  o_lanes,
    // Alarms and interrupt
    output logic [sacr_pkg::SACR_MON_BITS-1:0]     o_mon_alarm,
    output logic [sacr_pkg::SACR_LINK_BITS-1:0]    o_link_alarm,
    output logic [sacr_pkg::SACR_BC_BITS-1:0]      o_bc_alarm,
    output logic                                   o_irq,
    // Monitor state
    output logic                                   o_mon_run,
    output logic                                   o_volt0_sense,
    output logic                                   o_volt1_sense
);
    import sacr_pkg::*;

    logic [7:0]                sensor_ctrl_r;
    logic [7:0]                volt0_lim_r;
    logic [7:0]                volt1_lim_r;
    logic [7:0]                temp_lim_r;
    logic [7:0]                link_en_r;
    logic [7:0]                mon_en_r;
    logic [7:0]                bc_en_r;
    logic [7:0]                pol_r;
    logic [SACR_MON_BITS-1:0]  mon_st_r;
    logic [SACR_LINK_BITS-1:0] link_st_r;
    logic [SACR_BC_BITS-1:0]   bc_st_r;
    logic [SACR_MON_BITS-1:0]  mon_set;
    logic [2:0]                peak_r;
    logic [2:0]                floor_r;
    logic [7:0]                rdata_nxt;
    logic [7:0]                rdata_r;
    logic [2:0]                volt1_upper_limit;
    logic [2:0]                volt1_lower_limit;
    logic [2:0]                temp_upper_limit;
    logic [2:0]                temp_lower_limit;
    logic                      volt1_high_flag;
    logic                      volt1_low_flag;
    logic                      over_temp_flag;
    logic                      under_temp_flag;
    logic [SACR_LANES-1:0]     lane_swap;
    logic                      volt0_high_flag;
    logic                      volt0_low_flag;
    logic [SACR_MON_BITS-1:0]  mon_on;
    logic [SACR_LINK_BITS-1:0] link_on;
    logic [SACR_BC_BITS-1:0]   bc_on;
    // Named alarm enable bits
    logic                      no_frame_alarm_on;
    logic                      phy_sync_alarm_on;
    logic                      phy_ctrl_alarm_on;
    logic                      ecc_alarm_on;
    logic                      checksum_alarm_on;
    logic                      length_alarm_on;
    logic                      over_temp_alarm_on;
    logic                      under_temp_alarm_on;
    logic                      volt1_over_alarm_on;
    logic                      volt1_under_alarm_on;
    logic                      volt0_over_alarm_on;
    logic                      volt0_under_alarm_on;
    logic                      bc_target_timeout_alarm_on;
    logic                      bc_target_fault_alarm_on;
    logic                      bc_ctrl_timeout_alarm_on;
    logic                      bc_ctrl_fault_alarm_on;
    logic                      bc_data_fault_alarm_on;
    logic                      bc_crc_alarm_on;
    logic                      bc_link_alarm_on;
    // Named lane swap bits
    logic                      clock_lane_swap;
    logic                      lane3_swap;
    logic                      lane2_swap;
    logic                      lane1_swap;
    logic                      lane0_swap;

    // Write hit on one offset
    function automatic logic wr_hit(input sacr_bus_req_t req, input logic [7:0] ofs);
        wr_hit = req.wr && (req.addr == ofs);
    endfunction : wr_hit

    // Upper field of a limit byte
    function automatic logic [2:0] upper_of(input logic [7:0] lim);
        upper_of = lim[SACR_UPPER_LSB +: 3];
    endfunction : upper_of

    // Lower field of a limit byte
    function automatic logic [2:0] lower_of(input logic [7:0] lim);
        lower_of = lim[SACR_LOWER_LSB +: 3];
    endfunction : lower_of

    // Monitor control and pin selection
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sensor_ctrl_r <= SACR_SENSOR_CTRL_RST;
        end else if (wr_hit(i_bus, SACR_SENSOR_CTRL_OFS)) begin
            sensor_ctrl_r <= i_bus.wdata;
        end
    end

    assign o_mon_run     = sensor_ctrl_r[SACR_MON_RUN_LSB +: 2] == SACR_MON_RUN;
    assign o_volt0_sense = o_mon_run && sensor_ctrl_r[SACR_PIN_SEL_LSB];
    assign o_volt1_sense = o_mon_run && sensor_ctrl_r[SACR_PIN_SEL_LSB + 1];

    // Limit registers; reserved bits are plain storage
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            volt0_lim_r <= SACR_LIM_RST;
        end else if (wr_hit(i_bus, SACR_VOLT0_LIM_OFS)) begin
            volt0_lim_r <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            volt1_lim_r <= SACR_LIM_RST;
        end else if (wr_hit(i_bus, SACR_VOLT1_LIM_OFS)) begin
            volt1_lim_r <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            temp_lim_r <= SACR_LIM_RST;
        end else if (wr_hit(i_bus, SACR_TEMP_LIM_OFS)) begin
            temp_lim_r <= i_bus.wdata;
        end
    end

    // Alarm enable registers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            link_en_r <= SACR_LINK_EN_RST;
        end else if (wr_hit(i_bus, SACR_LINK_EN_OFS)) begin
            link_en_r <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mon_en_r <= SACR_MON_EN_RST;
        end else if (wr_hit(i_bus, SACR_MON_EN_OFS)) begin
            mon_en_r <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bc_en_r <= SACR_BC_EN_RST;
        end else if (wr_hit(i_bus, SACR_BC_EN_OFS)) begin
            bc_en_r <= i_bus.wdata;
        end
    end

    // Polarity; upper three bits are read-only zero
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pol_r <= SACR_POL_RST;
        end else if (wr_hit(i_bus, SACR_POL_OFS)) begin
            pol_r <= i_bus.wdata & SACR_POL_MASK;
        end
    end

    assign {clock_lane_swap, lane3_swap, lane2_swap, lane1_swap, lane0_swap} =
        pol_r[SACR_LANES-1:0];
    assign lane_swap = {clock_lane_swap, lane3_swap, lane2_swap, lane1_swap, lane0_swap};

    // Registered lane path with per-lane P/N swap
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_lanes <= '0;
        end else begin
            for (int i = 0; i < SACR_LANES; i++) begin
                o_lanes.p[i] <= lane_swap[i] ? i_lanes.n[i] : i_lanes.p[i];
                o_lanes.n[i] <= lane_swap[i] ? i_lanes.p[i] : i_lanes.n[i];
            end
        end
    end

    // Threshold comparisons
    assign volt1_upper_limit = upper_of(volt1_lim_r);
    assign volt1_lower_limit = lower_of(volt1_lim_r);
    assign temp_upper_limit  = upper_of(temp_lim_r);
    assign temp_lower_limit  = lower_of(temp_lim_r);

    assign volt1_high_flag = o_volt1_sense && (i_meas.volt1 > volt1_upper_limit);
    assign volt1_low_flag  = o_volt1_sense && (i_meas.volt1 < volt1_lower_limit);
    assign over_temp_flag  = o_mon_run && (i_meas.temp > temp_upper_limit);
    assign under_temp_flag = o_mon_run && (i_meas.temp < temp_lower_limit);
    assign volt0_high_flag = o_volt0_sense && (i_meas.volt0 > upper_of(volt0_lim_r));
    assign volt0_low_flag  = o_volt0_sense && (i_meas.volt0 < lower_of(volt0_lim_r));

    always_comb begin
        mon_set = '0;
        if (i_meas.vld) begin
            mon_set[SACR_T_OVER]  = over_temp_flag;
            mon_set[SACR_T_UNDER] = under_temp_flag;
            mon_set[SACR_VOLT1_OVER_ALARM_ON] = volt1_high_flag;
            mon_set[SACR_V1_UNDR] = volt1_low_flag;
            mon_set[SACR_VOLT0_OVER_ALARM_ON] = volt0_high_flag;
            mon_set[SACR_V0_UNDR] = volt0_low_flag;
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mon_st_r <= '0;
        end else if (wr_hit(i_bus, SACR_MON_ST_OFS)) begin
            mon_st_r <= (mon_st_r & ~i_bus.wdata[SACR_MON_BITS-1:0]) | mon_set;
        end else begin
            mon_st_r <= mon_st_r | mon_set;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            link_st_r <= '0;
        end else if (wr_hit(i_bus, SACR_LINK_ST_OFS)) begin
            link_st_r <= (link_st_r & ~i_bus.wdata[SACR_LINK_BITS-1:0]) | i_link_err;
        end else begin
            link_st_r <= link_st_r | i_link_err;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bc_st_r <= '0;
        end else if (wr_hit(i_bus, SACR_BC_ST_OFS)) begin
            bc_st_r <= (bc_st_r & ~i_bus.wdata[SACR_BC_BITS-1:0]) | i_bc_err;
        end else begin
            bc_st_r <= bc_st_r | i_bc_err;
        end
    end

    // Volt1 extremes while volt1 sensing is active
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            peak_r  <= SACR_PEAK_RST;
            floor_r <= SACR_FLOOR_RST;
        end else if (i_meas.vld && o_volt1_sense) begin
            if (i_meas.volt1 > peak_r) begin
                peak_r <= i_meas.volt1;
            end
            if (i_meas.volt1 < floor_r) begin
                floor_r <= i_meas.volt1;
            end
        end
    end

    // Link receive alarm enables
    assign no_frame_alarm_on = link_en_r[SACR_NO_FRAME];
    assign phy_sync_alarm_on = link_en_r[SACR_PHY_SYNC];
    assign phy_ctrl_alarm_on = link_en_r[SACR_PHY_CTRL];
    assign ecc_alarm_on      = link_en_r[SACR_HDR_ECC];
    assign checksum_alarm_on = link_en_r[SACR_CHKSUM];
    assign length_alarm_on   = link_en_r[SACR_PKT_LEN];

    // Monitor alarm enables
    assign over_temp_alarm_on   = mon_en_r[SACR_T_OVER];
    assign under_temp_alarm_on  = mon_en_r[SACR_T_UNDER];
    assign volt1_over_alarm_on  = mon_en_r[SACR_VOLT1_OVER_ALARM_ON];
    assign volt1_under_alarm_on = mon_en_r[SACR_V1_UNDR];
    assign volt0_over_alarm_on  = mon_en_r[SACR_VOLT0_OVER_ALARM_ON];
    assign volt0_under_alarm_on = mon_en_r[SACR_V0_UNDR];

    // Back-channel alarm enables; crc and link detect are plain enables
    assign bc_target_timeout_alarm_on = bc_en_r[SACR_TGT_TMO];
    assign bc_target_fault_alarm_on   = bc_en_r[SACR_TGT_FAULT];
    assign bc_ctrl_timeout_alarm_on   = bc_en_r[SACR_CTL_TMO];
    assign bc_ctrl_fault_alarm_on     = bc_en_r[SACR_CTL_FAULT];
    assign bc_data_fault_alarm_on     = bc_en_r[SACR_BC_DATA];
    assign bc_crc_alarm_on            = bc_en_r[SACR_BC_CRC];
    assign bc_link_alarm_on           = bc_en_r[SACR_BC_LINK];

    // Enable vectors in status bit order
    assign mon_on  = {over_temp_alarm_on, under_temp_alarm_on, volt1_over_alarm_on,
                      volt1_under_alarm_on, volt0_over_alarm_on, volt0_under_alarm_on};
    assign link_on = {no_frame_alarm_on, phy_sync_alarm_on, phy_ctrl_alarm_on,
                      ecc_alarm_on, checksum_alarm_on, length_alarm_on};
    assign bc_on   = {bc_target_timeout_alarm_on, bc_target_fault_alarm_on,
                      bc_ctrl_timeout_alarm_on, bc_ctrl_fault_alarm_on,
                      bc_data_fault_alarm_on, bc_crc_alarm_on, bc_link_alarm_on};

    // Active alarms need both the event and its enable
    assign o_mon_alarm  = mon_st_r & mon_on;
    assign o_link_alarm = link_st_r & link_on;
    assign o_bc_alarm   = bc_st_r & bc_on;
    assign o_irq        = |{o_mon_alarm, o_link_alarm, o_bc_alarm};

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_bus.addr == SACR_SENSOR_CTRL_OFS) begin
            rdata_nxt = sensor_ctrl_r;
        end else if (i_bus.addr == SACR_VOLT0_LIM_OFS) begin
            rdata_nxt = volt0_lim_r;
        end else if (i_bus.addr == SACR_VOLT1_LIM_OFS) begin
            rdata_nxt = volt1_lim_r;
        end else if (i_bus.addr == SACR_TEMP_LIM_OFS) begin
            rdata_nxt = temp_lim_r;
        end else if (i_bus.addr == SACR_LINK_EN_OFS) begin
            rdata_nxt = link_en_r;
        end else if (i_bus.addr == SACR_MON_EN_OFS) begin
            rdata_nxt = mon_en_r;
        end else if (i_bus.addr == SACR_BC_EN_OFS) begin
            rdata_nxt = bc_en_r;
        end else if (i_bus.addr == SACR_POL_OFS) begin
            rdata_nxt = pol_r;
        end else if (i_bus.addr == SACR_MON_ST_OFS) begin
            rdata_nxt = {2'h0, mon_st_r};
        end else if (i_bus.addr == SACR_LINK_ST_OFS) begin
            rdata_nxt = {2'h0, link_st_r};
        end else if (i_bus.addr == SACR_BC_ST_OFS) begin
            rdata_nxt = {1'h0, bc_st_r};
        end else if (i_bus.addr == SACR_PEAK_OFS) begin
            rdata_nxt = {5'h00, peak_r};
        end else if (i_bus.addr == SACR_FLOOR_OFS) begin
            rdata_nxt = {5'h00, floor_r};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_r <= 8'h00;
        end else if (i_bus.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign o_rdata = rdata_r;
endmodule : sacr_regs

// File: sim/sacr_regs_assertions.sv
`timescale 1ns/1ps
module sacr_chk (
    // Clock and reset
    input wire logic                    i_sys_clk,
    input wire logic                    i_rst_b,
    // Register port
    input wire sacr_pkg::sacr_bus_req_t i_bus,
    input wire logic [7:0]              o_rdata,
    // Events and lanes
    input wire sacr_pkg::sacr_meas_t    i_meas,
    input wire logic [5:0]              i_link_err,
    input wire logic [6:0]              i_bc_err,
    input wire sacr_pkg::sacr_lanes_t   i_lanes,
    input wire sacr_pkg::sacr_lanes_t   o_lanes,
    // Alarms and monitor state
    input wire logic [5:0]              o_mon_alarm,
    input wire logic [5:0]              o_link_alarm,
    input wire logic [6:0]              o_bc_alarm,
    input wire logic                    o_irq,
    input wire logic                    o_mon_run,
    input wire logic                    o_volt0_sense,
    input wire logic                    o_volt1_sense
);
    import sacr_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    property p_rdata_idle;
        $past(i_rst_b) && !$past(i_bus.rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
    // A swap keeps the P xor N of each lane
    property p_lane_swap;
        $past(i_rst_b) |-> (o_lanes.p ^ o_lanes.n) == ($past(i_lanes.p) ^ $past(i_lanes.n));
    endproperty
    a_lane_swap: assert property (p_lane_swap) else $error("lane pair broken");
    property p_irq;
        o_irq == |{o_mon_alarm, o_link_alarm, o_bc_alarm};
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_sense;
        o_volt0_sense || o_volt1_sense |-> o_mon_run;
    endproperty
    a_sense: assert property (p_sense) else $error("sense without run");
    property p_link_rise;
        |(o_link_alarm & ~$past(o_link_alarm)) |-> |$past(i_link_err) || $past(i_bus.wr);
    endproperty
    a_link_rise: assert property (p_link_rise) else $error("link alarm no cause");
    property p_bc_rise;
        |(o_bc_alarm & ~$past(o_bc_alarm)) |-> |$past(i_bc_err) || $past(i_bus.wr);
    endproperty
    a_bc_rise: assert property (p_bc_rise) else $error("bc alarm no cause");
    property p_mon_rise;
        |(o_mon_alarm & ~$past(o_mon_alarm)) |-> $past(i_meas.vld) || $past(i_bus.wr);
    endproperty
    a_mon_rise: assert property (p_mon_rise) else $error("mon alarm no cause");
    property p_mon_fall;
        |(~o_mon_alarm & $past(o_mon_alarm)) |-> $past(i_bus.wr);
    endproperty
    a_mon_fall: assert property (p_mon_fall) else $error("mon alarm lost");
    property p_unmapped;
        i_bus.rd && i_bus.addr == 8'h00 |=> o_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_pol_rsvd;
        i_bus.rd && i_bus.addr == SACR_POL_OFS |=> o_rdata[7:5] == 3'h0;
    endproperty
    a_pol_rsvd: assert property (p_pol_rsvd) else $error("pol reserved set");
endmodule : sacr_chk

// File: sim/sacr_sensor_model.sv
`timescale 1ns/1ps
module sacr_sensor_model (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_b,
    // Lanes toward the receiver
    output sacr_pkg::sacr_lanes_t o_lanes
);
    import sacr_pkg::*;
    logic [9:0] seq_r;
    // P and N kept independent so a swap shows
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seq_r <= 10'h155;
        end else begin
            seq_r <= seq_r + 10'h0D3;
        end
    end
    assign o_lanes = seq_r;
endmodule : sacr_sensor_model

// File: sim/sensor_alarm_config_regs_tb_top.sv
`timescale 1ns/1ps
bind sacr_regs sacr_chk chk_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_meas(i_meas), .i_link_err(i_link_err), .i_bc_err(i_bc_err),
    .i_lanes(i_lanes), .o_lanes(o_lanes), .o_mon_alarm(o_mon_alarm),
    .o_link_alarm(o_link_alarm), .o_bc_alarm(o_bc_alarm), .o_irq(o_irq),
    .o_mon_run(o_mon_run), .o_volt0_sense(o_volt0_sense), .o_volt1_sense(o_volt1_sense));
module sensor_alarm_config_regs_tb_top;
    import sacr_pkg::*;
    logic          clk;
    logic          rst_b;
    sacr_bus_req_t bus;
    logic [7:0]    rdata;
    sacr_meas_t    meas;
    logic [5:0]    lerr;
    logic [6:0]    berr;
    sacr_lanes_t   lanes;
    sacr_lanes_t   lanes_q;
    sacr_lanes_t   lanes_o;
    logic [5:0]    mon_al;
    logic [5:0]    link_al;
    logic [6:0]    bc_al;
    logic          irq;
    logic          run;
    logic          s0;
    logic          s1;
    logic [4:0]    m;
    int            error_cnt;
    int            samples_checked;

    sacr_regs dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_bus(bus), .o_rdata(rdata),
        .i_meas(meas), .i_link_err(lerr), .i_bc_err(berr), .i_lanes(lanes),
        .o_lanes(lanes_o), .o_mon_alarm(mon_al), .o_link_alarm(link_al),
        .o_bc_alarm(bc_al), .o_irq(irq), .o_mon_run(run), .o_volt0_sense(s0),
        .o_volt1_sense(s1));
    sacr_sensor_model sensor_u (.i_sys_clk(clk), .i_rst_b(rst_b), .o_lanes(lanes));

    always #5 clk = ~clk;
    always @(posedge clk) lanes_q <= lanes;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask : rd
    task automatic smp(input logic [2:0] t, input logic [2:0] v);
        meas <= '{1'b1, v, v, t};
        @(posedge clk);
        meas.vld <= 1'b0;
        @(posedge clk);
    endtask : smp
    task automatic ev(input logic [5:0] l, input logic [6:0] b);
        lerr <= l;
        berr <= b;
        @(posedge clk);
        lerr <= 6'h00;
        berr <= 7'h00;
        @(posedge clk);
    endtask : ev
    task automatic summarize;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        bus = '0;
        meas = '0;
        lerr = '0;
        berr = '0;
        error_cnt = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(SACR_SENSOR_CTRL_OFS, 8'h3C);
        rd(SACR_VOLT0_LIM_OFS, 8'h62);
        rd(SACR_VOLT1_LIM_OFS, 8'h62);
        rd(SACR_TEMP_LIM_OFS, 8'h62);
        rd(SACR_LINK_EN_OFS, 8'h3F);
        rd(SACR_MON_EN_OFS, 8'h00);
        rd(SACR_BC_EN_OFS, 8'h00);
        rd(SACR_POL_OFS, 8'h00);
        wr(SACR_POL_OFS, 8'hFF);
        rd(SACR_POL_OFS, 8'h1F);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        wr(SACR_VOLT1_LIM_OFS, 8'h51);
        rd(SACR_VOLT1_LIM_OFS, 8'h51);
        for (int i = 0; i < 2; i++) begin
            m = i ? 5'h0A : 5'h1F;
            wr(SACR_POL_OFS, {3'h0, m});
            repeat (3) begin
                @(negedge clk);
                chk({3'h0, lanes_o.p}, {3'h0, (lanes_q.p & ~m) | (lanes_q.n & m)});
                chk({3'h0, lanes_o.n}, {3'h0, (lanes_q.n & ~m) | (lanes_q.p & m)});
            end
            @(posedge clk);
        end
        for (int i = 0; i < 16; i++) begin
            wr(SACR_SENSOR_CTRL_OFS, {4'h3, i[3:0]});
            #1 chk({5'h00, run, s1, s0}, {5'h00, i[3:2] == 2'h3,
                (i[3:2] == 2'h3) & i[1], (i[3:2] == 2'h3) & i[0]});
            @(posedge clk);
        end
        // Volt1 sensing only; limits at the edge raise nothing
        wr(SACR_SENSOR_CTRL_OFS, 8'h3E);
        wr(SACR_MON_EN_OFS, 8'h3F);
        smp(3'h6, 3'h1);
        #1 chk({2'h0, mon_al}, 8'h00);
        smp(3'h7, 3'h0);
        #1 chk({2'h0, mon_al}, 8'h24);
        smp(3'h1, 3'h6);
        #1 chk({1'b0, irq, mon_al}, 8'h7C);
        rd(SACR_MON_ST_OFS, 8'h3C);
        rd(SACR_PEAK_OFS, 8'h06);
        rd(SACR_FLOOR_OFS, 8'h00);
        wr(SACR_MON_EN_OFS, 8'h00);
        #1 chk({1'b0, irq, mon_al}, 8'h00);
        rd(SACR_MON_ST_OFS, 8'h3C);
        wr(SACR_MON_ST_OFS, 8'h3C);
        rd(SACR_MON_ST_OFS, 8'h00);
        // Volt0 sensing only; volt1 extremes stay put
        wr(SACR_SENSOR_CTRL_OFS, 8'h3D);
        wr(SACR_MON_EN_OFS, 8'h03);
        smp(3'h4, 3'h7);
        smp(3'h4, 3'h0);
        #1 chk({2'h0, mon_al}, 8'h03);
        rd(SACR_PEAK_OFS, 8'h06);
        rd(SACR_MON_ST_OFS, 8'h03);
        wr(SACR_MON_ST_OFS, 8'h03);
        wr(SACR_SENSOR_CTRL_OFS, 8'h32);
        smp(3'h7, 3'h7);
        rd(SACR_MON_ST_OFS, 8'h00);
        rd(SACR_PEAK_OFS, 8'h06);
        ev(6'h3F, 7'h00);
        #1 chk({1'b0, irq, link_al}, 8'h7F);
        wr(SACR_LINK_EN_OFS, 8'h1F);
        #1 chk({2'h0, link_al}, 8'h1F);
        rd(SACR_LINK_ST_OFS, 8'h3F);
        wr(SACR_LINK_ST_OFS, 8'h3F);
        #1 chk({1'b0, irq, link_al}, 8'h00);
        ev(6'h00, 7'h7F);
        #1 chk({irq, bc_al}, 8'h00);
        wr(SACR_BC_EN_OFS, 8'h7C);
        #1 chk({irq, bc_al}, 8'hFC);
        rd(SACR_BC_ST_OFS, 8'h7F);
        // Mid-run reset brings back the defaults
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(SACR_LINK_EN_OFS, 8'h3F);
        rd(SACR_MON_EN_OFS, 8'h00);
        rd(SACR_POL_OFS, 8'h00);
        rd(SACR_BC_ST_OFS, 8'h00);
        rd(SACR_PEAK_OFS, 8'h00);
        rd(SACR_FLOOR_OFS, 8'h07);
        #1 chk({7'h00, irq}, 8'h00);
        summarize();
    end
endmodule : sensor_alarm_config_regs_tb_top
